// File: src/lintc_pkg.sv
// Constants for the host-side transceiver mode controller
package lintc_pkg;
	// Clock
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Transceiver timing in ns, bus rate in bit/s
	localparam int unsigned EN_FILTER_NS = 50000;
	localparam int unsigned MODE_CHANGE_NS = 200000;
	localparam int unsigned NORMAL_INIT_NS = 100000;
	localparam int unsigned DOM_TIMEOUT_NS = 20000000;
	localparam int unsigned BUS_RATE_BPS = 20000;
	localparam int unsigned NS_PER_S = 1000000000;
	localparam int unsigned BIT_NS = NS_PER_S / BUS_RATE_BPS;
	// Least times round up; one extra cycle makes a hold strictly longer
	localparam int unsigned EN_CYC_DEF =
		(EN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int unsigned SETTLE_CYC_DEF =
		(MODE_CHANGE_NS + NORMAL_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Longest times round down
	localparam int unsigned DOM_CYC_DEF = DOM_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int unsigned BIT_CYC_DEF = BIT_NS / CLK_PERIOD_NS;
	// Pin levels
	localparam logic LVL_RECESSIVE = 1'b1;
	localparam logic LVL_DOMINANT = 1'b0;
	localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
	localparam logic [31:0] CNT_ONE = 32'h0000_0001;
	typedef enum logic [2:0] {
		ST_OFF, ST_LOW, ST_WAKE_UP, ST_NORMAL, ST_GO_LOW
	} lintc_state_t;
endpackage

// File: src/lintc_ctrl.sv
// Host-side mode, wake and transmit controller for a LIN transceiver
`timescale 1ns/1ns
`default_nettype none
module lintc_ctrl #(
	parameter int unsigned EN_CYC = lintc_pkg::EN_CYC_DEF,
	parameter int unsigned SETTLE_CYC = lintc_pkg::SETTLE_CYC_DEF,
	parameter int unsigned DOM_CYC = lintc_pkg::DOM_CYC_DEF,
	parameter int unsigned BIT_CYC = lintc_pkg::BIT_CYC_DEF
) (
	// Clock, reset, enable
	input wire logic CORE_CLK_IN,
	input wire logic RSTN_IN,
	input wire logic CE_IN,
	// User commands and status
	input wire logic GO_NORMAL_IN,
	input wire logic GO_LOW_IN,
	output logic NORMAL_OUT,
	output logic BUSY_OUT,
	output logic WAKE_REQ_OUT,
	output logic SUPPLY_OK_OUT,
	// User transmit stream
	input wire logic TX_VALID_IN,
	input wire logic TX_BIT_IN,
	output logic TX_READY_OUT,
	// User receive data
	output logic RX_BIT_OUT,
	output logic RX_VALID_OUT,
	// Transceiver pins
	output logic MODE_SELECT_OUT,
	output logic TXD_OUT,
	input wire logic RXD_IN,
	input wire logic SUPPLY_GOOD_N_IN
);
	import lintc_pkg::*;

	if (EN_CYC < 2 || SETTLE_CYC < 1 || BIT_CYC < 2 ||
		DOM_CYC <= BIT_CYC + 1) begin : g_bad_param
		$error("lintc_ctrl: timing parameters out of range");
	end

	// ----------------------------------------
	// Mode state machine
	// ----------------------------------------
	lintc_state_t state_ff;
	lintc_state_t nxt_state;
	logic [31:0] timer_ff;
	logic [31:0] nxt_timer;
	logic settled_ff;
	logic wake_ff;
	logic supply_ok;
	logic tx_idle;
	logic [1:0] cnt_ff;
	logic [31:0] bit_cnt_ff;

	assign supply_ok = SUPPLY_GOOD_N_IN;
	assign tx_idle = (cnt_ff == 2'h0) && (bit_cnt_ff == CNT_ZERO);

	always_comb begin
		nxt_state = state_ff;
		nxt_timer = (timer_ff == CNT_ZERO) ? CNT_ZERO : timer_ff - CNT_ONE;
		unique case (state_ff)
			ST_OFF: begin
				// Wait for supply-good before any mode request
				if (supply_ok) begin
					nxt_state = ST_LOW;
					nxt_timer = SETTLE_CYC;
				end
			end
			ST_LOW: begin
				if (GO_NORMAL_IN) begin
					nxt_state = ST_WAKE_UP;
					nxt_timer = EN_CYC + SETTLE_CYC;
				end
			end
			ST_WAKE_UP: begin
				if (timer_ff == CNT_ZERO) begin
					nxt_state = ST_NORMAL;
				end
			end
			ST_NORMAL: begin
				// Only leave with the line recessive and no bit in flight
				if (GO_LOW_IN && tx_idle) begin
					nxt_state = ST_GO_LOW;
					nxt_timer = EN_CYC;
				end
			end
			ST_GO_LOW: begin
				if (timer_ff == CNT_ZERO) begin
					nxt_state = ST_LOW;
					nxt_timer = SETTLE_CYC;
				end
			end
		endcase
		// Supply loss overrides everything
		if (!supply_ok) begin
			nxt_state = ST_OFF;
			nxt_timer = CNT_ZERO;
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			state_ff <= ST_OFF;
			timer_ff <= CNT_ZERO;
		end else if (CE_IN) begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
		end
	end

	// mode select low until told otherwise
	// held high through filter, change and init
	// local wake by a long high
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			MODE_SELECT_OUT <= 1'b0;
		end else if (CE_IN) begin
			MODE_SELECT_OUT <= (nxt_state == ST_WAKE_UP) ||
				(nxt_state == ST_NORMAL);
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			settled_ff <= 1'b0;
		end else if (CE_IN) begin
			settled_ff <= (state_ff == ST_LOW) && (timer_ff == CNT_ZERO);
		end
	end

	// wake request kept until normal is reached or supply is lost
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			wake_ff <= 1'b0;
		end else if (CE_IN) begin
			if (settled_ff && state_ff == ST_LOW && RXD_IN == LVL_DOMINANT) begin
				wake_ff <= 1'b1;
			end else if (state_ff == ST_NORMAL || state_ff == ST_OFF) begin
				wake_ff <= 1'b0;
			end
		end
	end

	assign NORMAL_OUT = (state_ff == ST_NORMAL);
	assign BUSY_OUT = (state_ff == ST_WAKE_UP) || (state_ff == ST_GO_LOW) ||
		(state_ff == ST_OFF);
	assign WAKE_REQ_OUT = wake_ff;
	assign SUPPLY_OK_OUT = supply_ok;

	// ----------------------------------------
	// Two-entry transmit buffer
	// ----------------------------------------
	logic mem_ff [2];
	logic wr_ptr_ff;
	logic rd_ptr_ff;
	logic push;
	logic pop;

	assign TX_READY_OUT = (cnt_ff != 2'h2);
	assign push = TX_VALID_IN && TX_READY_OUT;
	// Drain stalls outside normal, so the buffer really fills
	assign pop = (cnt_ff != 2'h0) && (bit_cnt_ff == CNT_ZERO) &&
		(state_ff == ST_NORMAL) && !GO_LOW_IN;

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else if (CE_IN) begin
			if (push) begin
				wr_ptr_ff <= !wr_ptr_ff;
			end
			if (pop) begin
				rd_ptr_ff <= !rd_ptr_ff;
			end
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (CE_IN && push) begin
			mem_ff[wr_ptr_ff] <= TX_BIT_IN;
		end
	end

	// ----------------------------------------
	// Bit timing and transmit pin
	// ----------------------------------------
	logic [31:0] dom_cnt_ff;

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			bit_cnt_ff <= CNT_ZERO;
		end else if (CE_IN) begin
			if (pop) begin
				bit_cnt_ff <= BIT_CYC - 1;
			end else if (bit_cnt_ff != CNT_ZERO) begin
				bit_cnt_ff <= bit_cnt_ff - CNT_ONE;
			end
		end
	end

	// never hold dominant up to the timeout
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			TXD_OUT <= LVL_RECESSIVE;
			dom_cnt_ff <= CNT_ZERO;
		end else if (CE_IN) begin
			// Run counter lags the pin by a cycle, hence the extra one
			if (pop && dom_cnt_ff + BIT_CYC + CNT_ONE < DOM_CYC) begin
				TXD_OUT <= mem_ff[rd_ptr_ff];
			end else if (pop || bit_cnt_ff == CNT_ZERO ||
				state_ff != ST_NORMAL) begin
				TXD_OUT <= LVL_RECESSIVE;
			end
			if (TXD_OUT == LVL_DOMINANT) begin
				dom_cnt_ff <= dom_cnt_ff + CNT_ONE;
			end else begin
				dom_cnt_ff <= CNT_ZERO;
			end
		end
	end

	// receive sampled in normal after init
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			RX_BIT_OUT <= LVL_RECESSIVE;
			RX_VALID_OUT <= 1'b0;
		end else if (CE_IN) begin
			RX_VALID_OUT <= (state_ff == ST_NORMAL);
			if (state_ff == ST_NORMAL) begin
				RX_BIT_OUT <= RXD_IN;
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic [31:0] en_hi_cnt_ff;
	logic [31:0] en_lo_cnt_ff;

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			en_hi_cnt_ff <= CNT_ZERO;
			en_lo_cnt_ff <= CNT_ZERO;
		end else if (CE_IN) begin
			en_hi_cnt_ff <= MODE_SELECT_OUT ? en_hi_cnt_ff + CNT_ONE : CNT_ZERO;
			en_lo_cnt_ff <= MODE_SELECT_OUT ? CNT_ZERO : en_lo_cnt_ff + CNT_ONE;
		end
	end

	property p_enter_normal;
		@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
		$rose(NORMAL_OUT) |-> en_hi_cnt_ff >= EN_CYC + SETTLE_CYC;
	endproperty
	a_enter_normal: assert property (p_enter_normal)
		else $error("normal entered before hold time");

	property p_leave_low_txd;
		@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
		state_ff == ST_GO_LOW |-> TXD_OUT == LVL_RECESSIVE && !MODE_SELECT_OUT;
	endproperty
	a_leave_low_txd: assert property (p_leave_low_txd)
		else $error("transmit not recessive while leaving normal");

	property p_leave_low_time;
		@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
		state_ff == ST_LOW && $past(state_ff) == ST_GO_LOW |->
			en_lo_cnt_ff >= EN_CYC;
	endproperty
	a_leave_low_time: assert property (p_leave_low_time)
		else $error("mode select low too briefly");

	property p_wake_hold;
		@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
		$rose(MODE_SELECT_OUT) && CE_IN && supply_ok |=>
			MODE_SELECT_OUT [*8];
	endproperty
	a_wake_hold: assert property (p_wake_hold)
		else $error("local wake pulse too short");

	property p_settle;
		@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
		$rose(wake_ff) |-> $past(settled_ff) && $past(state_ff) == ST_LOW;
	endproperty
	a_settle: assert property (p_settle)
		else $error("wake taken before settle time");

	property p_reset_low;
		@(posedge CORE_CLK_IN)
		!RSTN_IN |=> !MODE_SELECT_OUT && TXD_OUT == LVL_RECESSIVE;
	endproperty
	a_reset_low: assert property (p_reset_low)
		else $error("mode select not low after reset");

	property p_dom_limit;
		@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
		dom_cnt_ff < DOM_CYC;
	endproperty
	a_dom_limit: assert property (p_dom_limit)
		else $error("transmit dominant too long");

	property p_normal_rx;
		@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
		CE_IN && NORMAL_OUT |=> RX_VALID_OUT && RX_BIT_OUT == $past(RXD_IN);
	endproperty
	a_normal_rx: assert property (p_normal_rx)
		else $error("receive data not passed in normal");

	c_normal: cover property (@(posedge CORE_CLK_IN) $rose(NORMAL_OUT));
	c_wake: cover property (@(posedge CORE_CLK_IN) $rose(wake_ff));
	c_full: cover property (@(posedge CORE_CLK_IN) !TX_READY_OUT);
	c_low: cover property (@(posedge CORE_CLK_IN) state_ff == ST_GO_LOW);
endmodule
`default_nettype wire

// File: tb/lintc_dev_model.sv
// Behavioural transceiver model facing the controller
`timescale 1ns/1ns
`default_nettype none
module lintc_dev_model #(
	parameter int WK_T = 3,
	parameter int DOM_T = 20
) (
	// Clock and supply
	input wire logic clk_in,
	input wire logic pwr_ok_in,
	// Controller pins
	input wire logic mode_sel_in,
	input wire logic txd_in,
	output logic rxd_out,
	output logic sg_n_out,
	// Remote node pulling the bus dominant
	input wire logic bus_dom_in
);
	logic normal_ff, wake_ff, lock_ff;
	int wk_cnt_ff;
	int dto_cnt_ff;
	logic bus;
	// transmitter released after a long dominant
	always_ff @(posedge clk_in) begin
		dto_cnt_ff <= (txd_in || !normal_ff) ? 0 : dto_cnt_ff + 1;
	end
	assign bus = (txd_in | (dto_cnt_ff >= DOM_T)) & ~bus_dom_in;
	always_ff @(posedge clk_in) begin
		// recovery restarts from standby, select low
		if (!pwr_ok_in) begin
			normal_ff <= 1'b0;
			wake_ff <= 1'b0;
			lock_ff <= 1'b0;
			wk_cnt_ff <= 0;
		end else begin
			normal_ff <= mode_sel_in;
			if (normal_ff && !mode_sel_in)
				lock_ff <= bus_dom_in;
			else if (!bus_dom_in)
				lock_ff <= 1'b0;
			wk_cnt_ff <= bus_dom_in ? wk_cnt_ff + 1 : 0;
			if (!normal_ff && !bus_dom_in && wk_cnt_ff >= WK_T && !lock_ff)
				wake_ff <= 1'b1;
			if (normal_ff)
				wake_ff <= 1'b0;
		end
	end
	assign rxd_out = normal_ff ? bus : ~wake_ff;
	assign sg_n_out = pwr_ok_in;
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the transceiver mode controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import lintc_pkg::*;
	localparam int EN = 8;
	localparam int SET = 6;
	localparam int BITC = 4;
	localparam int DOM = 20;
	logic clk, rstn, ce, go_n, go_l, tx_v, tx_b, pwr, dom, b, saw_full;
	wire logic normal, busy, wake, sup_ok, rdy, rx_bit, rx_v, msel, txd, rxd;
	wire logic sg_n;
	int bad_count, n_tests, cyc, run, max_run, i, k;
	lintc_ctrl #(.EN_CYC(EN), .SETTLE_CYC(SET), .DOM_CYC(DOM),
		.BIT_CYC(BITC)) i_lintc_ctrl (
		.CORE_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce),
		.GO_NORMAL_IN(go_n), .GO_LOW_IN(go_l), .NORMAL_OUT(normal),
		.BUSY_OUT(busy), .WAKE_REQ_OUT(wake), .SUPPLY_OK_OUT(sup_ok),
		.TX_VALID_IN(tx_v), .TX_BIT_IN(tx_b), .TX_READY_OUT(rdy),
		.RX_BIT_OUT(rx_bit), .RX_VALID_OUT(rx_v), .MODE_SELECT_OUT(msel),
		.TXD_OUT(txd), .RXD_IN(rxd), .SUPPLY_GOOD_N_IN(sg_n));
	lintc_dev_model #(.DOM_T(DOM)) i_lintc_dev_model (.clk_in(clk),
		.pwr_ok_in(pwr), .mode_sel_in(msel), .txd_in(txd),
		.rxd_out(rxd), .sg_n_out(sg_n), .bus_dom_in(dom));
	// ----------------------------------------
	// Clock, hang guard, dominant run monitor
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) begin
		cyc++;
		run = (txd === LVL_DOMINANT) ? run + 1 : 0;
		if (run > max_run)
			max_run = run;
		if (cyc == 4000) begin
			bad_count++;
			stop_test;
		end
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic exp_rx(input logic d, input logic t);
		return t & ~d;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic push(input logic v);
		tx_v = 1'b1;
		tx_b = v;
		k = 0;
		while (rdy !== 1'b1 && k < 100) begin
			saw_full = 1'b1;
			tick(1);
			k++;
		end
		chk(1'b1, rdy);
		tick(1);
	endtask
	task automatic enter_normal;
		go_n = 1'b1;
		tick(1);
		go_n = 1'b0;
		tick(1);
		chk(1'b1, msel);
		tick(EN + SET - 1);
		chk(1'b0, normal);
		tick(1);
		chk(1'b1, normal);
		chk(1'b0, busy);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rstn, go_n, go_l, tx_v, pwr, dom, saw_full} = 7'h00;
		tx_b = 1'b1;
		ce = 1'b1;
		{bad_count, n_tests, cyc, run, max_run} = '0;
		void'($urandom(32'hcf4c));
		tick(16);
		rstn = 1'b1;
		tick(1);
		chk(1'b0, sup_ok);
		chk(1'b1, busy);
		pwr = 1'b1;
		tick(3);
		chk(1'b1, sup_ok);
		chk(1'b0, normal);
		$display("test power up done");
		// Enable low: a request must not be taken
		ce = 1'b0;
		go_n = 1'b1;
		tick(2);
		chk(1'b0, msel);
		chk(1'b0, normal);
		go_n = 1'b0;
		ce = 1'b1;
		tick(1);
		$display("test clock enable done");
		enter_normal;
		for (i = 0; i < 16; i++) begin
			dom = 1'($urandom % 2);
			b = dom;
			tick(1);
			chk(exp_rx(b, LVL_RECESSIVE), rx_bit);
			chk(1'b1, rx_v);
		end
		dom = 1'b0;
		for (i = 0; i < 8; i++) begin
			b = 1'($urandom % 2);
			push(b);
			tx_v = 1'b0;
			tick(1);
			chk(b, txd);
			tick(BITC - 1);
			chk(b, txd);
			tick(1);
			chk(LVL_RECESSIVE, txd);
		end
		$display("test normal traffic done");
		for (i = 0; i < 6; i++)
			push(LVL_DOMINANT);
		tx_v = 1'b0;
		tick(6 * BITC + 10);
		chk(1'b1, saw_full);
		chk(1'(max_run == 4 * BITC), 1'b1);
		$display("test dominant burst done");
		go_l = 1'b1;
		tick(1);
		go_l = 1'b0;
		tick(1);
		chk(1'b0, msel);
		chk(1'b0, normal);
		chk(1'b1, busy);
		chk(LVL_RECESSIVE, txd);
		k = 0;
		while (busy === 1'b1 && k < 50) begin
			tick(1);
			k++;
		end
		chk(1'b0, busy);
		tick(SET + 4);
		chk(1'b0, wake);
		dom = 1'b1;
		tick(5);
		chk(1'b0, wake);
		dom = 1'b0;
		tick(3);
		chk(1'b1, wake);
		enter_normal;
		// Request drops one cycle after normal is reached
		tick(1);
		chk(1'b0, wake);
		$display("test sleep and wake done");
		pwr = 1'b0;
		tick(1);
		chk(1'b0, sup_ok);
		chk(1'b0, msel);
		chk(1'b0, normal);
		$display("test supply loss done");
		stop_test;
	end
endmodule
`default_nettype wire
